// ==== core/igps_sequencer.sv ====
// Inverter gate pulse sequencer: half-cycle toggle, pulses, steering and interlock.
//
// Contract
// - A trailing edge with set steering high and clear steering low sets half.
// - Half set starts a 5 us pulse on both positive drives and negative commutate.
// - Each trailing edge starts a delay: low for 40 us, then high.
// - The delay output rising starts one 50 us commutation window.
// - In the set half the window drives positive-phase commutate for its width.
// - Window in set half resets steering; set side drops, clear rises after 10 us.
// - A trailing edge with steering favouring clear clears the half state.
// - Half clear starts a 5 us pulse on both negative drives and positive commutate.
// - In the clear half the window drives negative-phase commutate for its width.
// - Window in clear half sets steering; clear side drops, set rises after 10 us.
// - The two halves repeat forever, alternating on every oscillator pulse.
// - Interlock is high while the delay runs; the oscillator then sends nothing.
// - Steering delay keeps one power pair off before the other is fired.
`timescale 1ns/100ps
module igps_sequencer #(
   parameter int                CNT_W         = igps_pkg::CNT_W,
   parameter logic [CNT_W-1:0]  SHORT_CYCLES  = igps_pkg::SHORT_PULSE_CYCLES,
   parameter logic [CNT_W-1:0]  DELAY_CYCLES  = igps_pkg::DELAY_CYCLES,
   parameter logic [CNT_W-1:0]  WINDOW_CYCLES = igps_pkg::WINDOW_CYCLES,
   parameter logic [CNT_W-1:0]  DEAD_CYCLES   = igps_pkg::DEAD_TIME_CYCLES
) (
   input  wire logic            clock,
   input  wire logic            reset,
   input  wire logic            oscillator_pulse_in,
   output logic                 oscillator_inhibit,
   output logic                 pos_power_drive_first,
   output logic                 pos_power_drive_second,
   output logic                 neg_power_drive_first,
   output logic                 neg_power_drive_second,
   output logic                 pos_phase_commutate_drive,
   output logic                 neg_phase_commutate_drive
);

   igps_tmr_if short_tmr ();
   igps_tmr_if delay_tmr ();
   igps_tmr_if window_tmr ();
   igps_tmr_if j_tmr ();
   igps_tmr_if k_tmr ();

   igps_pulse_timer #(.CNT_W(CNT_W), .LENGTH(SHORT_CYCLES)) u_short (
      .clock (clock),
      .reset (reset),
      .tmr   (short_tmr.timer)
   );

   igps_pulse_timer #(.CNT_W(CNT_W), .LENGTH(DELAY_CYCLES)) u_delay (
      .clock (clock),
      .reset (reset),
      .tmr   (delay_tmr.timer)
   );

   igps_pulse_timer #(.CNT_W(CNT_W), .LENGTH(WINDOW_CYCLES)) u_window (
      .clock (clock),
      .reset (reset),
      .tmr   (window_tmr.timer)
   );

   igps_pulse_timer #(.CNT_W(CNT_W), .LENGTH(DEAD_CYCLES)) u_j_dead (
      .clock (clock),
      .reset (reset),
      .tmr   (j_tmr.timer)
   );

   igps_pulse_timer #(.CNT_W(CNT_W), .LENGTH(DEAD_CYCLES)) u_k_dead (
      .clock (clock),
      .reset (reset),
      .tmr   (k_tmr.timer)
   );

   logic                osc_prev;
   igps_pkg::igps_half_t half;
   igps_pkg::igps_half_t next_half;
   logic                steer;
   logic                next_steer;
   logic                j_steer;
   logic                next_j_steer;
   logic                k_steer;
   logic                next_k_steer;

   wire trailing_edge = osc_prev & ~oscillator_pulse_in;
   wire half_pos      = (half == igps_pkg::HALF_POS);
   wire jk_set        = trailing_edge & j_steer & ~k_steer;
   wire jk_clear      = trailing_edge & ~j_steer & k_steer;
   wire jk_toggle     = trailing_edge & j_steer & k_steer;
   wire half_change   = (next_half != half);
   wire window_pulse  = window_tmr.busy;
   wire steer_to_clr  = window_pulse & half_pos;
   wire steer_to_set  = window_pulse & ~half_pos;

   assign next_half = jk_set    ? igps_pkg::HALF_POS :
                      jk_clear  ? igps_pkg::HALF_NEG :
                      jk_toggle ? (half_pos ? igps_pkg::HALF_NEG : igps_pkg::HALF_POS) :
                      half;

   assign short_tmr.start  = half_change;
   assign delay_tmr.start  = trailing_edge;
   assign window_tmr.start = delay_tmr.done;

   assign next_steer = steer_to_clr ? 1'h0 :
                       steer_to_set ? 1'h1 : steer;

   assign j_tmr.start  = next_steer & ~steer;
   assign k_tmr.start  = ~next_steer & steer;
   assign next_j_steer = ~steer ? 1'h0 : (j_tmr.done ? 1'h1 : j_steer);
   assign next_k_steer = steer ? 1'h0 : (k_tmr.done ? 1'h1 : k_steer);

   wire short_pos = short_tmr.busy & half_pos;
   wire short_neg = short_tmr.busy & ~half_pos;

   wire next_pos_comm = short_neg | (window_pulse & half_pos);
   wire next_neg_comm = short_pos | (window_pulse & ~half_pos);
   wire next_inhibit  = delay_tmr.busy;

   always_ff @(posedge clock) begin
      if (reset) begin
         osc_prev <= 1'h0;
         half     <= igps_pkg::HALF_RESET;
         steer    <= igps_pkg::STEER_RESET;
         j_steer  <= igps_pkg::J_STEER_RESET;
         k_steer  <= igps_pkg::K_STEER_RESET;
      end else begin
         osc_prev <= oscillator_pulse_in;
         half     <= next_half;
         steer    <= next_steer;
         j_steer  <= next_j_steer;
         k_steer  <= next_k_steer;
      end
   end

   // Drives are registered so the gate drivers never see decode glitches.
   always_ff @(posedge clock) begin
      if (reset) begin
         oscillator_inhibit        <= igps_pkg::DRIVE_RESET;
         pos_power_drive_first     <= igps_pkg::DRIVE_RESET;
         pos_power_drive_second    <= igps_pkg::DRIVE_RESET;
         neg_power_drive_first     <= igps_pkg::DRIVE_RESET;
         neg_power_drive_second    <= igps_pkg::DRIVE_RESET;
         pos_phase_commutate_drive <= igps_pkg::DRIVE_RESET;
         neg_phase_commutate_drive <= igps_pkg::DRIVE_RESET;
      end else begin
         oscillator_inhibit        <= next_inhibit;
         pos_power_drive_first     <= short_pos;
         pos_power_drive_second    <= short_pos;
         neg_power_drive_first     <= short_neg;
         neg_power_drive_second    <= short_neg;
         pos_phase_commutate_drive <= next_pos_comm;
         neg_phase_commutate_drive <= next_neg_comm;
      end
   end

   default clocking cb @(posedge clock);
   endclocking

   default disable iff (reset);

   sequence s_pos_fire;
      pos_power_drive_first & pos_power_drive_second & neg_phase_commutate_drive;
   endsequence

   sequence s_neg_fire;
      neg_power_drive_first & neg_power_drive_second & pos_phase_commutate_drive;
   endsequence

   sequence s_set_drop_clr_wait;
      !steer ##1 (!j_steer && !k_steer) [*8];
   endsequence

   sequence s_clr_drop_set_wait;
      steer ##1 (!k_steer && !j_steer) [*8];
   endsequence

   a_half_set_edge: assert property (jk_set |=> half_pos)
      else $error("Half state did not set on trailing edge.");

   a_half_clr_edge: assert property (jk_clear |=> !half_pos)
      else $error("Half state did not clear on trailing edge.");

   a_pos_short_fire: assert property ($rose(half_pos) |=> ##1 s_pos_fire [*8])
      else $error("Positive short pulse missing after half set.");

   a_neg_short_fire: assert property ($fell(half_pos) |=> ##1 s_neg_fire [*8])
      else $error("Negative short pulse missing after half clear.");

   a_delay_start_low: assert property (trailing_edge |=> ##1 oscillator_inhibit [*8])
      else $error("Delay output not held low after trailing edge.");

   a_window_at_delay: assert property ($fell(delay_tmr.busy) |-> window_pulse)
      else $error("Window did not start as delay ended.");

   a_pos_comm_gate: assert property (window_pulse && half_pos |=> pos_phase_commutate_drive)
      else $error("Positive commutate not gated by window.");

   a_neg_comm_gate: assert property (window_pulse && !half_pos |=> neg_phase_commutate_drive)
      else $error("Negative commutate not gated by window.");

   a_steer_to_clear: assert property (steer && steer_to_clr |=> s_set_drop_clr_wait)
      else $error("Steering reset did not drop set side with dead time.");

   a_steer_to_set: assert property (!steer && steer_to_set |=> s_clr_drop_set_wait)
      else $error("Steering set did not drop clear side with dead time.");

   a_inhibit_follows: assert property (delay_tmr.busy |=> oscillator_inhibit)
      else $error("Interlock low while delay runs.");

   a_no_steer_overlap: assert property (!(j_steer && k_steer))
      else $error("Both steering inputs high together.");

   a_reset_state: assert property (@(posedge clock) disable iff (1'b0)
      reset |=> (!half_pos && steer && j_steer && !oscillator_inhibit
                 && !pos_power_drive_first && !neg_power_drive_first))
      else $error("Reset state wrong.");

endmodule

// ==== include/igps_pkg.sv ====
// Constants, timing figures and types shared by the gate pulse sequencer.
package igps_pkg;

   localparam int CLOCK_PERIOD_PS = 25000;
   localparam int CNT_W           = 12;

   // Times in microseconds, as the sequencer is specified.
   localparam int OSC_PERIOD_US   = 100;
   localparam int SHORT_PULSE_US  = 5;
   localparam int DELAY_US        = 40;
   localparam int WINDOW_US       = 50;
   localparam int DEAD_TIME_US    = 10;

   localparam int PS_PER_US       = 1000000;

   // Least time to whole clock cycles, rounded up, never below one.
   function automatic logic [CNT_W-1:0] us_to_cycles(input int us);
      int cycles;
      cycles = (us * PS_PER_US + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
      if (cycles < 1) begin
         cycles = 1;
      end
      return CNT_W'(cycles);
   endfunction

   localparam logic [CNT_W-1:0] OSC_PERIOD_CYCLES  = us_to_cycles(OSC_PERIOD_US);
   localparam logic [CNT_W-1:0] SHORT_PULSE_CYCLES = us_to_cycles(SHORT_PULSE_US);
   localparam logic [CNT_W-1:0] DELAY_CYCLES       = us_to_cycles(DELAY_US);
   localparam logic [CNT_W-1:0] WINDOW_CYCLES      = us_to_cycles(WINDOW_US);
   localparam logic [CNT_W-1:0] DEAD_TIME_CYCLES   = us_to_cycles(DEAD_TIME_US);

   typedef enum logic [0:0] {
      HALF_NEG = 1'h0,
      HALF_POS = 1'h1
   } igps_half_t;

   localparam igps_half_t HALF_RESET     = HALF_NEG;
   localparam logic       STEER_RESET    = 1'h1;
   localparam logic       J_STEER_RESET  = 1'h1;
   localparam logic       K_STEER_RESET  = 1'h0;
   localparam logic       DRIVE_RESET    = 1'h0;

endpackage

// ==== include/igps_tmr_if.sv ====
// Start and status signals between the sequencer and one of its interval timers.
`timescale 1ns/100ps
interface igps_tmr_if;
   logic start;
   logic busy;
   logic done;

   modport timer (
      input  start,
      output busy,
      output done
   );

   modport user (
      output start,
      input  busy,
      input  done
   );
endinterface

// ==== core/igps_pulse_timer.sv ====
// Retriggerable one-shot interval timer used for every pulse and delay.
`timescale 1ns/100ps
module igps_pulse_timer #(
   parameter int                 CNT_W  = igps_pkg::CNT_W,
   parameter logic [CNT_W-1:0]   LENGTH = igps_pkg::SHORT_PULSE_CYCLES
) (
   input  wire logic             clock,
   input  wire logic             reset,
   igps_tmr_if.timer             tmr
);

   localparam logic [CNT_W-1:0] CNT_ZERO = {CNT_W{1'b0}};
   localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] next_count;

   // Busy lasts exactly LENGTH cycles, starting the cycle after start.
   assign next_count = tmr.start ? LENGTH :
                       (count != CNT_ZERO) ? count - CNT_ONE : CNT_ZERO;
   assign tmr.busy   = (count != CNT_ZERO);
   assign tmr.done   = (count == CNT_ONE);

   always_ff @(posedge clock) begin
      if (reset) begin
         count <= CNT_ZERO;
      end else begin
         count <= next_count;
      end
   end

endmodule

// ==== test/igps_osc_model.sv ====
// Oscillator pulse source that feeds the sequencer and obeys its interlock.
`timescale 1ns/100ps
module igps_osc_model #(
   parameter int PERIOD = 100,
   parameter int HIGH   = 4
) (
   input  wire logic clock,
   input  wire logic run,
   input  wire logic oscillator_inhibit,
   output logic      oscillator_pulse_in
);
   int count;

   initial begin
      oscillator_pulse_in = 1'h0;
      count = 0;
   end

   always @(posedge clock) begin
      if (!run || count == PERIOD - 1) begin
         count <= 0;
      end else begin
         count <= count + 1;
      end
   end

   always @(posedge clock) begin
      oscillator_pulse_in <= run && !oscillator_inhibit && (count < HIGH);
   end
endmodule

// ==== test/igps_sequencer_tb.sv ====
// Self-checking bench for the gate pulse sequencer driven by an oscillator model.
`timescale 1ns/100ps
module inverter_gate_pulse_sequencer_tb_top;
   localparam logic [igps_pkg::CNT_W-1:0] SHORT = 12'h00A;
   localparam logic [igps_pkg::CNT_W-1:0] DLY   = 12'h028;
   localparam logic [igps_pkg::CNT_W-1:0] WIN   = 12'h032;
   localparam logic [igps_pkg::CNT_W-1:0] DEAD  = 12'h00A;

   logic       clock;
   logic       reset;
   logic       run;
   logic       osc;
   logic       inhibit;
   logic       ppf;
   logic       pps;
   logic       npf;
   logic       nps;
   logic       pcd;
   logic       ncd;
   logic [6:0] outs;
   int         err_total;
   int         tests_run;

   assign outs = {ppf, pps, npf, nps, pcd, ncd, inhibit};

   igps_sequencer #(
      .SHORT_CYCLES (SHORT),
      .DELAY_CYCLES (DLY),
      .WINDOW_CYCLES(WIN),
      .DEAD_CYCLES  (DEAD)
   ) i_igps_sequencer (
      .clock                    (clock),
      .reset                    (reset),
      .oscillator_pulse_in      (osc),
      .oscillator_inhibit       (inhibit),
      .pos_power_drive_first    (ppf),
      .pos_power_drive_second   (pps),
      .neg_power_drive_first    (npf),
      .neg_power_drive_second   (nps),
      .pos_phase_commutate_drive(pcd),
      .neg_phase_commutate_drive(ncd)
   );

   igps_osc_model #(.PERIOD(100), .HIGH(4)) i_igps_osc_model (
      .clock              (clock),
      .run                (run),
      .oscillator_inhibit (inhibit),
      .oscillator_pulse_in(osc)
   );

   initial begin
      clock = 1'h0;
      forever #12.5 clock = ~clock;
   end

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic compare(input logic [6:0] got, input logic [6:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected outputs at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Expected drive pattern at the m-th clock edge after the oscillator output fell.
   function automatic logic [6:0] expect_at(input int m, input logic pos);
      logic sh;
      logic inh;
      logic win;
      sh  = (m >= 2) && (m <= SHORT + 1);
      inh = (m >= 2) && (m <= DLY + 1);
      win = (m >= DLY + 2) && (m <= DLY + WIN + 1);
      return pos ? {sh, sh, 1'h0, 1'h0, win, sh, inh} : {1'h0, 1'h0, sh, sh, sh, win, inh};
   endfunction

   // Returns at the falling clock edge just before the sequencer takes a trailing edge.
   task automatic wait_fall();
      logic prev;
      int   n;
      prev = osc;
      for (n = 0; n < 300; n++) begin
         @(negedge clock);
         if (prev === 1'h1 && osc === 1'h0) begin
            return;
         end
         prev = osc;
      end
      err_total++;
      $display("unexpected timeout at %0t: got %h expected %h", $time, 1'h0, 1'h1);
      finish_test();
   endtask

   task automatic run_half(input logic pos);
      int pts [8];
      int cur;
      int i;
      pts = '{1, 2, SHORT + 1, SHORT + 2, DLY + 1, DLY + 2, DLY + WIN + 1, DLY + WIN + 2};
      wait_fall();
      // The fall is launched at the edge before wait_fall returns, so count from zero.
      cur = 0;
      for (i = 0; i < 8; i++) begin
         while (cur < pts[i]) begin
            @(negedge clock);
            cur++;
         end
         compare(outs, expect_at(pts[i], pos));
      end
   endtask

   task automatic test_reset();
      @(negedge clock);
      compare(outs, 7'h00);
      @(posedge clock);
      reset <= 1'h0;
      @(negedge clock);
      compare(outs, 7'h00);
      @(posedge clock);
      run <= 1'h1;
      @(negedge clock);
      compare(outs, 7'h00);
   endtask

   task automatic test_first_pos();
      run_half(1'h1);
   endtask

   task automatic test_then_neg();
      run_half(1'h0);
   endtask

   task automatic test_repeat();
      run_half(1'h1);
      run_half(1'h0);
   endtask

   // A reset inside a positive window must restart on the positive half.
   task automatic test_mid_reset();
      wait_fall();
      repeat (60) @(negedge clock);
      @(posedge clock);
      reset <= 1'h1;
      run   <= 1'h0;
      repeat (3) @(posedge clock);
      @(negedge clock);
      compare(outs, 7'h00);
      @(posedge clock);
      reset <= 1'h0;
      run   <= 1'h1;
      run_half(1'h1);
   endtask

   initial begin
      err_total = 0;
      tests_run = 0;
      reset     = 1'h1;
      run       = 1'h0;
      repeat (19) @(posedge clock);
      test_reset();
      test_first_pos();
      test_then_neg();
      test_repeat();
      test_mid_reset();
      finish_test();
   end
endmodule
